// ### hw/hd_sync_pkg.sv
// Functional notes
// - trigger loads event type pointer from bits 6:4 of trigger state four
// - trigger presets 10-bit duration counter, upper bits 1:0 of state four; counts down
// - trigger presets 10-bit line counter from trigger state; counts down afterwards
// - horizontal trigger phase is 12 bits in pixel clocks, high nibble plus low byte
// - vertical trigger phase is 10 bits in input lines, bits 1:0 plus low byte
// - output control bit 2 selects rgb (zero, reset) or yuv processing
// - output control bit 1 zero (reset) applies reduced gain leaving sync headroom
// - output control bit 1 one gives full-range swing for full-range input
// - output control bit 0 zero interpolates colour difference in yuv mode only (bit 2 one); one bypasses it
package hd_sync_pkg;

   // ==========================================================
   // register subaddresses
   localparam logic [7:0] ADDR_STATE_ONE   = 8'hd4;
   localparam logic [7:0] ADDR_STATE_TWO   = 8'hd5;
   localparam logic [7:0] ADDR_STATE_THREE = 8'hd6;
   localparam logic [7:0] ADDR_STATE_FOUR  = 8'hd7;
   localparam logic [7:0] ADDR_PHASE_X_LO  = 8'hd8;
   localparam logic [7:0] ADDR_PHASE_X_HI  = 8'hd9;
   localparam logic [7:0] ADDR_PHASE_Y_LO  = 8'hda;
   localparam logic [7:0] ADDR_PHASE_Y_HI  = 8'hdb;
   localparam logic [7:0] ADDR_OUT_CTRL    = 8'hdc;
   localparam logic [7:0] ADDR_ENG_STATUS  = 8'hdd;

   // ==========================================================
   // field positions
   localparam int EPT_MSB      = 6;
   localparam int EPT_LSB      = 4;
   localparam int CNT_HI_MSB   = 1;
   localparam int LTP_MSB      = 7;
   localparam int LTP_LSB      = 4;
   localparam int PPT_MSB      = 3;
   localparam int PPT_LSB      = 2;
   localparam int PHX_HI_MSB   = 3;
   localparam int PHY_HI_MSB   = 1;
   localparam int CTL_ENGINE   = 3;
   localparam int CTL_YUV      = 2;
   localparam int CTL_FULL     = 1;
   localparam int CTL_INTP_OFF = 0;

   // ==========================================================
   // reset values and widths
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int PHX_W   = 12;
   localparam int LINE_W  = 10;
   localparam int SMP_W   = 10;
   // reduced gain factor, out = in * num / 256
   localparam logic [8:0] GAIN_REDUCED_NUM = 9'h0db;
   localparam int GAIN_SHIFT = 8;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [SMP_W-1:0] y_g;
      logic [SMP_W-1:0] cb_b;
      logic [SMP_W-1:0] cr_r;
   } sample_s;

   typedef struct packed {
      logic [LINE_W-1:0] line_cnt;
      logic [LINE_W-1:0] dur_cnt;
      logic [3:0]        line_type_ptr;
      logic [1:0]        pattern_ptr;
      logic [2:0]        event_ptr;
   } engine_state_s;

   typedef struct packed {
      logic engine_on;
      logic yuv;
      logic full_swing;
      logic interp_off;
   } path_ctrl_s;

endpackage

// ### hw/hd_path_proc.sv
`timescale 1ns/10ps
module hd_path_proc (
   // clock and reset
   input  wire logic                 mclk,
   input  wire logic                 srst,
   // control
   input  wire hd_sync_pkg::path_ctrl_s ctrl,
   // sample stream
   input  wire logic                 pix_en,
   input  wire hd_sync_pkg::sample_s in_smp,
   output hd_sync_pkg::sample_s      out_smp
);

   localparam int PW = hd_sync_pkg::SMP_W + 9;

   hd_sync_pkg::sample_s prev_ff;
   hd_sync_pkg::sample_s out_ff;
   hd_sync_pkg::sample_s nxt_out;
   hd_sync_pkg::sample_s interp;

   // ==========================================================
   // colour difference interpolation
   // averaging only makes sense on colour difference, so rgb passes untouched
   wire do_interp = ctrl.yuv & ~ctrl.interp_off;
   wire [hd_sync_pkg::SMP_W:0] cb_sum = {1'b0, in_smp.cb_b} + {1'b0, prev_ff.cb_b};
   wire [hd_sync_pkg::SMP_W:0] cr_sum = {1'b0, in_smp.cr_r} + {1'b0, prev_ff.cr_r};

   assign interp.y_g  = in_smp.y_g;
   assign interp.cb_b = do_interp ? cb_sum[hd_sync_pkg::SMP_W:1] : in_smp.cb_b;
   assign interp.cr_r = do_interp ? cr_sum[hd_sync_pkg::SMP_W:1] : in_smp.cr_r;

   // ==========================================================
   // gain stage
   function automatic logic [hd_sync_pkg::SMP_W-1:0] scale(
      input logic [hd_sync_pkg::SMP_W-1:0] v,
      input logic                          full
   );
      logic [PW-1:0] prod;
      prod = {9'h000, v} * {{(PW-9){1'b0}}, hd_sync_pkg::GAIN_REDUCED_NUM};
      if (full) begin
         scale = v;
      end else begin
         scale = prod[hd_sync_pkg::GAIN_SHIFT +: hd_sync_pkg::SMP_W];
      end
   endfunction

   assign nxt_out.y_g  = scale(interp.y_g,  ctrl.full_swing);
   assign nxt_out.cb_b = scale(interp.cb_b, ctrl.full_swing);
   assign nxt_out.cr_r = scale(interp.cr_r, ctrl.full_swing);

   always_ff @(posedge mclk) begin
      if (srst) begin
         prev_ff <= '0;
         out_ff  <= '0;
      end else if (pix_en) begin
         prev_ff <= in_smp;
         out_ff  <= nxt_out;
      end
   end

   assign out_smp = out_ff;

endmodule

// ### hw/hd_sync_trigger_output_ctrl.sv
`timescale 1ns/10ps
module hd_sync_trigger_output_ctrl (
   // clock and reset
   input  wire logic                       mclk,
   input  wire logic                       srst,
   // register port from the serial control decoder
   input  wire logic [7:0]                 reg_addr,
   input  wire logic                       reg_wr,
   input  wire logic [7:0]                 reg_wdata,
   input  wire logic                       reg_rd,
   output logic [7:0]                      reg_rdata,
   // input timing
   input  wire logic                       pix_en,
   input  wire logic                       line_start,
   input  wire logic                       frame_start,
   // sample path
   input  wire hd_sync_pkg::sample_s       in_smp,
   output hd_sync_pkg::sample_s            out_smp,
   // engine side
   output hd_sync_pkg::path_ctrl_s         path_ctrl,
   output logic                            trigger_pulse,
   output hd_sync_pkg::engine_state_s      engine_state
);

   localparam int PHX_W  = hd_sync_pkg::PHX_W;
   localparam int LINE_W = hd_sync_pkg::LINE_W;

   // register bytes
   logic [7:0] state_one_ff;
   logic [7:0] state_two_ff;
   logic [7:0] state_three_ff;
   logic [7:0] sync_trigger_state_four_ff;
   logic [7:0] trigger_phase_x_low_ff;
   logic [7:0] trigger_phase_x_high_ff;
   logic [7:0] trigger_phase_y_low_ff;
   logic [7:0] trigger_phase_y_high_ff;
   logic [7:0] hd_output_control_ff;
   logic [7:0] rdata_ff;

   // position, trigger and engine state
   logic [PHX_W-1:0]  hpos_ff;
   logic [LINE_W-1:0] vpos_ff;
   logic              triggered_ff;
   logic              trig_ff;
   hd_sync_pkg::engine_state_s eng_ff;
   hd_sync_pkg::engine_state_s nxt_eng;
   hd_sync_pkg::engine_state_s preset;

   // ==========================================================
   // register write decode
   // one strobe per writable byte; the status byte has none
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = (a == target);
   endfunction

   wire wr_s1  = reg_wr & hit(reg_addr, hd_sync_pkg::ADDR_STATE_ONE);
   wire wr_s2  = reg_wr & hit(reg_addr, hd_sync_pkg::ADDR_STATE_TWO);
   wire wr_s3  = reg_wr & hit(reg_addr, hd_sync_pkg::ADDR_STATE_THREE);
   wire wr_s4  = reg_wr & hit(reg_addr, hd_sync_pkg::ADDR_STATE_FOUR);
   wire wr_xlo = reg_wr & hit(reg_addr, hd_sync_pkg::ADDR_PHASE_X_LO);
   wire wr_xhi = reg_wr & hit(reg_addr, hd_sync_pkg::ADDR_PHASE_X_HI);
   wire wr_ylo = reg_wr & hit(reg_addr, hd_sync_pkg::ADDR_PHASE_Y_LO);
   wire wr_yhi = reg_wr & hit(reg_addr, hd_sync_pkg::ADDR_PHASE_Y_HI);
   wire wr_ctl = reg_wr & hit(reg_addr, hd_sync_pkg::ADDR_OUT_CTRL);

   // unused bits are stored as written; software keeps them zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_one_ff               <= hd_sync_pkg::REG_RESET;
         state_two_ff               <= hd_sync_pkg::REG_RESET;
         state_three_ff             <= hd_sync_pkg::REG_RESET;
         sync_trigger_state_four_ff <= hd_sync_pkg::REG_RESET;
         trigger_phase_x_low_ff     <= hd_sync_pkg::REG_RESET;
         trigger_phase_x_high_ff    <= hd_sync_pkg::REG_RESET;
         trigger_phase_y_low_ff     <= hd_sync_pkg::REG_RESET;
         trigger_phase_y_high_ff    <= hd_sync_pkg::REG_RESET;
         hd_output_control_ff       <= hd_sync_pkg::REG_RESET;
      end else begin
         if (wr_s1)  state_one_ff               <= reg_wdata;
         if (wr_s2)  state_two_ff               <= reg_wdata;
         if (wr_s3)  state_three_ff             <= reg_wdata;
         if (wr_s4)  sync_trigger_state_four_ff <= reg_wdata;
         if (wr_xlo) trigger_phase_x_low_ff     <= reg_wdata;
         if (wr_xhi) trigger_phase_x_high_ff    <= reg_wdata;
         if (wr_ylo) trigger_phase_y_low_ff     <= reg_wdata;
         if (wr_yhi) trigger_phase_y_high_ff    <= reg_wdata;
         if (wr_ctl) hd_output_control_ff       <= reg_wdata;
      end
   end

   // ==========================================================
   // read back
   // status is read only; a write to it matches no strobe and is dropped
   wire [7:0] status_byte;
   assign status_byte[7:2] = 6'h00;
   assign status_byte[1]   = trig_ff;
   assign status_byte[0]   = triggered_ff;
   // unmapped addresses read as zero
   wire [7:0] rd_mux =
      hit(reg_addr, hd_sync_pkg::ADDR_STATE_ONE)   ? state_one_ff               :
      hit(reg_addr, hd_sync_pkg::ADDR_STATE_TWO)   ? state_two_ff               :
      hit(reg_addr, hd_sync_pkg::ADDR_STATE_THREE) ? state_three_ff             :
      hit(reg_addr, hd_sync_pkg::ADDR_STATE_FOUR)  ? sync_trigger_state_four_ff :
      hit(reg_addr, hd_sync_pkg::ADDR_PHASE_X_LO)  ? trigger_phase_x_low_ff     :
      hit(reg_addr, hd_sync_pkg::ADDR_PHASE_X_HI)  ? trigger_phase_x_high_ff    :
      hit(reg_addr, hd_sync_pkg::ADDR_PHASE_Y_LO)  ? trigger_phase_y_low_ff     :
      hit(reg_addr, hd_sync_pkg::ADDR_PHASE_Y_HI)  ? trigger_phase_y_high_ff    :
      hit(reg_addr, hd_sync_pkg::ADDR_OUT_CTRL)    ? hd_output_control_ff       :
      hit(reg_addr, hd_sync_pkg::ADDR_ENG_STATUS)  ? status_byte                :
      8'h00;

   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         rdata_ff <= rd_mux;
      end
   end

   assign reg_rdata = rdata_ff;

   // ==========================================================
   // control fields
   // bits 7:4 are stored for read back only and drive nothing
   assign path_ctrl.engine_on  = hd_output_control_ff[hd_sync_pkg::CTL_ENGINE];
   assign path_ctrl.yuv        = hd_output_control_ff[hd_sync_pkg::CTL_YUV];
   assign path_ctrl.full_swing = hd_output_control_ff[hd_sync_pkg::CTL_FULL];
   assign path_ctrl.interp_off = hd_output_control_ff[hd_sync_pkg::CTL_INTP_OFF];

   // ==========================================================
   // trigger phase
   wire [PHX_W-1:0] trigger_phase_horiz = {trigger_phase_x_high_ff[hd_sync_pkg::PHX_HI_MSB:0],
                                           trigger_phase_x_low_ff};
   wire [LINE_W-1:0] trigger_phase_vert = {trigger_phase_y_high_ff[hd_sync_pkg::PHY_HI_MSB:0],
                                           trigger_phase_y_low_ff};

   // position counters; a new line wins over the pixel step
   // both counters wrap silently; a phase beyond the line or frame never matches
   always_ff @(posedge mclk) begin
      if (srst) begin
         hpos_ff <= '0;
         vpos_ff <= '0;
      end else begin
         if (line_start) begin
            hpos_ff <= '0;
         end else if (pix_en) begin
            hpos_ff <= hpos_ff + 12'h001;
         end
         if (frame_start) begin
            vpos_ff <= '0;
         end else if (line_start) begin
            vpos_ff <= vpos_ff + 10'h001;
         end
      end
   end

   // a pixel that coincides with line_start belongs to the new line, so it never matches
   wire h_match  = (hpos_ff == trigger_phase_horiz);
   wire v_match  = (vpos_ff == trigger_phase_vert);
   wire trig_hit = path_ctrl.engine_on & pix_en & ~line_start & h_match & v_match;

   // ==========================================================
   // preset values
   // presets are read live; a byte written in the trigger cycle lands after the load
   assign preset.line_cnt      = {state_two_ff[hd_sync_pkg::CNT_HI_MSB:0], state_one_ff};
   assign preset.dur_cnt       = {sync_trigger_state_four_ff[hd_sync_pkg::CNT_HI_MSB:0],
                                  state_three_ff};
   assign preset.line_type_ptr = state_two_ff[hd_sync_pkg::LTP_MSB:hd_sync_pkg::LTP_LSB];
   assign preset.pattern_ptr   = state_two_ff[hd_sync_pkg::PPT_MSB:hd_sync_pkg::PPT_LSB];
   assign preset.event_ptr     = sync_trigger_state_four_ff[hd_sync_pkg::EPT_MSB:
                                                            hd_sync_pkg::EPT_LSB];

   // ==========================================================
   // engine counters
   // the sequencer that walks the arrays advances the pointers; here they are held
   // the duration counter wraps below zero; the sequencer reloads it before then
   always_comb begin
      nxt_eng = eng_ff;
      if (trig_hit) begin
         nxt_eng = preset;
      end else if (triggered_ff) begin
         if (line_start) begin
            nxt_eng.line_cnt = eng_ff.line_cnt - 10'h001;
         end
         if (pix_en) begin
            nxt_eng.dur_cnt = eng_ff.dur_cnt - 10'h001;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         eng_ff       <= '0;
         triggered_ff <= 1'b0;
         trig_ff      <= 1'b0;
      end else if (!path_ctrl.engine_on) begin
         // disabling drops the engine so the next enable waits for a fresh trigger
         eng_ff       <= '0;
         triggered_ff <= 1'b0;
         trig_ff      <= 1'b0;
      end else begin
         eng_ff       <= nxt_eng;
         triggered_ff <= triggered_ff | trig_hit;
         trig_ff      <= trig_hit;
      end
   end

   // the pulse is registered so it lines up with the loaded state
   assign trigger_pulse = trig_ff;
   assign engine_state  = eng_ff;

   // ==========================================================
   // output path
   // a control write reaches the samples from the next pixel on
   hd_path_proc u_path (
      .mclk    (mclk),
      .srst    (srst),
      .ctrl    (path_ctrl),
      .pix_en  (pix_en),
      .in_smp  (in_smp),
      .out_smp (out_smp)
   );

endmodule

// ### bench/hd_sync_trigger_output_ctrl_properties.sv
`timescale 1ns/10ps
module hd_sync_trigger_output_ctrl_properties (
   // clock and reset
   input wire logic                       mclk,
   input wire logic                       srst,
   // register port
   input wire logic [7:0]                 reg_addr,
   input wire logic                       reg_wr,
   input wire logic [7:0]                 reg_wdata,
   input wire logic                       reg_rd,
   input wire logic [7:0]                 reg_rdata,
   // timing and samples
   input wire logic                       pix_en,
   input wire logic                       line_start,
   input wire logic                       frame_start,
   input wire hd_sync_pkg::sample_s       in_smp,
   input wire hd_sync_pkg::sample_s       out_smp,
   // engine side
   input wire hd_sync_pkg::path_ctrl_s    path_ctrl,
   input wire logic                       trigger_pulse,
   input wire hd_sync_pkg::engine_state_s engine_state
);
   // ==========================================================
   // shadow of the writable bytes, previous sample for the average
   logic [7:0]  sh_ff [0:8];
   logic        armed_ff;
   logic [19:0] prev_ff;
   wire         in_map = reg_addr >= 8'hd4 && reg_addr <= 8'hdc;
   wire         unmap  = reg_addr < 8'hd4 || reg_addr > 8'hdd;
   wire  [3:0]  idx    = 4'(reg_addr - 8'hd4);
   wire  [7:0]  rd_exp = in_map ? sh_ff[idx] : 8'h00;
   wire  [9:0]  red_y  = 10'((20'(in_smp.y_g) * 20'(hd_sync_pkg::GAIN_REDUCED_NUM)) >> 8);
   wire  [9:0]  avg_cr = 10'((11'(in_smp.cr_r) + 11'(prev_ff[9:0])) >> 1);
   hd_sync_pkg::engine_state_s pre;
   assign pre = {sh_ff[1][1:0], sh_ff[0], sh_ff[3][1:0], sh_ff[2],
                 sh_ff[1][7:4], sh_ff[1][3:2], sh_ff[3][6:4]};

   // armed only counts after a load; a disable drops it
   always_ff @(posedge mclk) begin
      if (srst) begin
         sh_ff    <= '{default: 8'h00};
         armed_ff <= 1'b0;
         prev_ff  <= 20'h00000;
      end else begin
         if (reg_wr && in_map)
            sh_ff[idx] <= reg_wdata;
         armed_ff <= path_ctrl.engine_on && (armed_ff || trigger_pulse);
         if (pix_en)
            prev_ff <= {in_smp.cb_b, in_smp.cr_r};
      end
   end

   // ==========================================================
   // properties
   default clocking dclk @(posedge mclk); endclocking
   default disable iff (srst);

   reset_idle_a: assert property ($fell(srst) |-> path_ctrl == 4'h0 && !trigger_pulse)
      else $error("outputs not idle after reset");
   ctrl_write_a: assert property (reg_wr && reg_addr == 8'hdc
      |=> path_ctrl == $past(reg_wdata[3:0])) else $error("control bits not taken");
   read_back_a: assert property (reg_rd && !reg_wr && (in_map || unmap)
      |=> reg_rdata == $past(rd_exp)) else $error("read data differs from written byte");
   preset_load_a: assert property (trigger_pulse |-> engine_state == pre)
      else $error("engine state not loaded from presets");
   single_pulse_a: assert property (trigger_pulse |=> !trigger_pulse)
      else $error("trigger pulse longer than one cycle");
   off_no_trig_a: assert property (!path_ctrl.engine_on |=> !trigger_pulse)
      else $error("trigger while engine off");
   off_zero_a: assert property (!path_ctrl.engine_on [*2] |-> engine_state == '0)
      else $error("engine state not cleared while off");
   dur_down_a: assert property (armed_ff && path_ctrl.engine_on && pix_en && !reg_wr
      |=> trigger_pulse || engine_state.dur_cnt == $past(engine_state.dur_cnt) - 10'h001)
      else $error("duration counter not counting down");
   line_down_a: assert property (armed_ff && path_ctrl.engine_on && line_start && !reg_wr
      |=> engine_state.line_cnt == $past(engine_state.line_cnt) - 10'h001)
      else $error("line counter not counting down");
   full_pass_a: assert property (pix_en && path_ctrl.full_swing
      && (path_ctrl.interp_off || !path_ctrl.yuv) |=> out_smp == $past(in_smp))
      else $error("full swing path altered the sample");
   reduced_gain_a: assert property (pix_en && !path_ctrl.full_swing && !path_ctrl.yuv
      |=> out_smp.y_g == $past(red_y)) else $error("reduced gain value wrong");
   interp_avg_a: assert property (pix_en && path_ctrl.full_swing && path_ctrl.yuv
      && !path_ctrl.interp_off |=> out_smp.cr_r == $past(avg_cr)) else $error("average wrong");

   trig_c: cover property (trigger_pulse);
   interp_c: cover property (pix_en && path_ctrl.yuv && !path_ctrl.interp_off);
   off_c: cover property ($fell(path_ctrl.engine_on));
endmodule

// ### bench/hd_sync_trigger_output_ctrl_tb_top.sv
`timescale 1ns/10ps
module hd_sync_trigger_output_ctrl_tb_top;
   typedef struct packed {
      logic [3:0]           ctrl;
      hd_sync_pkg::sample_s din;
      hd_sync_pkg::sample_s dout;
   } row_s;

   // ==========================================================
   // stimulus and observed signals
   logic                       mclk        = 1'b0;
   logic                       srst        = 1'b1;
   logic [7:0]                 reg_addr    = 8'h00;
   logic                       reg_wr      = 1'b0;
   logic [7:0]                 reg_wdata   = 8'h00;
   logic                       reg_rd      = 1'b0;
   logic [7:0]                 reg_rdata;
   logic                       pix_en      = 1'b0;
   logic                       line_start  = 1'b0;
   logic                       frame_start = 1'b0;
   hd_sync_pkg::sample_s       in_smp      = '0;
   hd_sync_pkg::sample_s       out_smp;
   hd_sync_pkg::path_ctrl_s    path_ctrl;
   logic                       trigger_pulse;
   hd_sync_pkg::engine_state_s engine_state;
   hd_sync_pkg::engine_state_s exp_es      = {10'h235, 10'h147, 4'ha, 2'h1, 3'h5};
   int                         fails       = 0;
   int                         n_checks    = 0;
   int                         hit;
   // presets d4..d7, phase x = 3, phase y = 2, control off; reserved bits kept zero
   logic [7:0] vals [9] = '{8'h35, 8'ha6, 8'h47, 8'h51, 8'h03, 8'h00, 8'h02, 8'h00, 8'h00};
   row_s rows [5] = '{
      '{4'h2, {10'h100, 10'h200, 10'h300}, {10'h100, 10'h200, 10'h300}},
      '{4'h0, {10'h100, 10'h200, 10'h3ff}, {10'h0db, 10'h1b6, 10'h36b}},
      '{4'h6, {10'h100, 10'h200, 10'h300}, {10'h100, 10'h200, 10'h37f}},
      '{4'h7, {10'h010, 10'h020, 10'h030}, {10'h010, 10'h020, 10'h030}},
      '{4'h4, {10'h200, 10'h100, 10'h300}, {10'h1b6, 10'h07b, 10'h15d}}};

   hd_sync_trigger_output_ctrl dut (.mclk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
      .reg_rdata, .pix_en, .line_start, .frame_start, .in_smp, .out_smp, .path_ctrl,
      .trigger_pulse, .engine_state);

   always #4 mclk = ~mclk;

   // ==========================================================
   // shared tasks; every access leaves one idle cycle so strobes never toggle twice
   task automatic tick();
      @(posedge mclk);
      #1;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      tick();
      reg_wr = 1'b0;
      tick();
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      reg_rd   = 1'b1;
      tick();
      reg_rd = 1'b0;
      chk(reg_rdata, e);
      tick();
   endtask

   // three lines of eight pixels; hit records line * 8 + pixel of the pulse
   task automatic frame();
      hit = -1;
      for (int l = 0; l < 3; l++) begin
         line_start  = 1'b1;
         frame_start = (l == 0);
         tick();
         line_start  = 1'b0;
         frame_start = 1'b0;
         for (int p = 0; p < 8; p++) begin
            pix_en = 1'b1;
            tick();
            if (trigger_pulse === 1'b1) begin
               hit = l * 8 + p;
               chk(engine_state, exp_es);
            end
         end
         pix_en = 1'b0;
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (12) tick();
      srst = 1'b0;
      for (int a = 8'hd4; a <= 8'hdd; a++)
         rd(8'(a), 8'h00);
      chk(engine_state, 29'h0);
      foreach (rows[i]) begin
         wr(hd_sync_pkg::ADDR_OUT_CTRL, {4'h0, rows[i].ctrl});
         chk(path_ctrl, rows[i].ctrl);
         in_smp = rows[i].din;
         pix_en = 1'b1;
         tick();
         pix_en = 1'b0;
         chk(out_smp, rows[i].dout);
      end
      foreach (vals[i])
         wr(8'hd4 + 8'(i), vals[i]);
      foreach (vals[i])
         rd(8'hd4 + 8'(i), vals[i]);
      wr(8'he0, 8'hff);
      rd(8'he0, 8'h00);
      wr(8'hdd, 8'hff);
      rd(8'hdd, 8'h00);
      wr(hd_sync_pkg::ADDR_OUT_CTRL, 8'h08);
      // second frame re-triggers and must reload the same presets
      for (int n = 0; n < 2; n++) begin
         frame();
         chk(hit, 19);
         chk(engine_state.dur_cnt, 10'h143);
      end
      rd(8'hdd, 8'h01);
      wr(hd_sync_pkg::ADDR_OUT_CTRL, 8'h00);
      chk(engine_state, 29'h0);
      frame();
      chk(hit, -1);
      wr(hd_sync_pkg::ADDR_OUT_CTRL, 8'h0f);
      srst = 1'b1;
      tick();
      srst = 1'b0;
      chk(path_ctrl, 4'h0);
      tick();
      chk({reg_rdata, trigger_pulse}, 9'h000);
      wrap_up();
   end
endmodule

bind hd_sync_trigger_output_ctrl hd_sync_trigger_output_ctrl_properties chk_i (.mclk, .srst,
   .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .pix_en, .line_start, .frame_start,
   .in_smp, .out_smp, .path_ctrl, .trigger_pulse, .engine_state);
